/* File: hdl/itc_alu.sv */
// arithmetic unit: add, subtract, multiply, divide with flag results
`timescale 1ns/10ps
module itc_alu
  import itc_pkg::*;
#(
  parameter int WIDTH = itc_pkg::BYTE_W
) (
  // operation and operands
  input  wire itc_pkg::itc_alu_op_t op,
  input  wire logic [WIDTH-1:0]     opA,
  input  wire logic [WIDTH-1:0]     opB,
  input  wire logic                 carryIn,
  // results
  output logic      [WIDTH-1:0]     result,
  output logic      [WIDTH-1:0]     resultHi,
  output logic                      carryOut,
  output logic                      wrapOut,
  output logic                      auxOut
);

  localparam int HALF = WIDTH / 2;

  generate
    if (WIDTH < 4 || (WIDTH % 2) != 0) begin : g_bad_width
      $error("itc_alu: WIDTH must be even and at least 4");
    end
  endgenerate

  logic [WIDTH:0]     full;
  logic [WIDTH-1:0]   low7;
  logic [HALF:0]      nib;
  logic [2*WIDTH-1:0] prod;

  always_comb begin
    full     = '0;
    low7     = '0;
    nib      = '0;
    prod     = '0;
    result   = opA;
    resultHi = opB;
    carryOut = 1'b0;
    wrapOut  = 1'b0;
    auxOut   = 1'b0;
    case (op)
      ALU_ADD: begin
        full     = {1'b0, opA} + {1'b0, opB} + {{WIDTH{1'b0}}, carryIn};
        low7     = {1'b0, opA[WIDTH-2:0]} + {1'b0, opB[WIDTH-2:0]} + {{(WIDTH-1){1'b0}}, carryIn};
        nib      = {1'b0, opA[HALF-1:0]} + {1'b0, opB[HALF-1:0]} + {{HALF{1'b0}}, carryIn};
        result   = full[WIDTH-1:0];
        carryOut = full[WIDTH];
        wrapOut  = full[WIDTH] ^ low7[WIDTH-1];
        auxOut   = nib[HALF];
      end
      ALU_SUB: begin
        full     = {1'b0, opA} - {1'b0, opB} - {{WIDTH{1'b0}}, carryIn};
        low7     = {1'b0, opA[WIDTH-2:0]} - {1'b0, opB[WIDTH-2:0]} - {{(WIDTH-1){1'b0}}, carryIn};
        nib      = {1'b0, opA[HALF-1:0]} - {1'b0, opB[HALF-1:0]} - {{HALF{1'b0}}, carryIn};
        result   = full[WIDTH-1:0];
        carryOut = full[WIDTH];
        wrapOut  = full[WIDTH] ^ low7[WIDTH-1];
        auxOut   = nib[HALF];
      end
      ALU_MUL: begin
        prod     = {{WIDTH{1'b0}}, opA} * {{WIDTH{1'b0}}, opB};
        result   = prod[WIDTH-1:0];
        resultHi = prod[2*WIDTH-1:WIDTH];
        wrapOut  = |prod[2*WIDTH-1:WIDTH];
      end
      ALU_DIV: begin
        // divide by zero leaves both operands and flags the wrap
        if (opB == '0) begin
          wrapOut = 1'b1;
        end else begin
          result   = opA / opB;
          resultHi = opA % opB;
        end
      end
      default: begin
        result = opA;
      end
    endcase
  end

endmodule

/* File: hdl/itc_core.sv */
// core sequencer: four-clock machine cycles, decode timing, flag updates
`timescale 1ns/10ps
// Functional notes
// - machine cycle is four system clocks
// - at most one code fetch per cycle
// - cycle count equals instruction byte count, except for jumps
// - jumps and calls take one extra cycle
// - flag effects match the classic instruction set
// - add, add_with_carry, subtract_with_borrow update carry, wrap, aux
// - mul/div clear carry; carry-only ops listed
// - nop, add forms decode to one/two cycles
// - second accumulator register at f0
// - wrap flag is carry6 xor carry7 for add and subtract forms
// - odd-ones flag tracks accumulator continuously
// - aux carry from low nibble
module itc_core
  import itc_pkg::*;
#(
  parameter int ADDR_W = itc_pkg::PC_W
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // program memory fetch
  output logic                               fetchReq,
  output logic      [ADDR_W-1:0]             fetchAddr,
  input  wire logic [itc_pkg::BYTE_W-1:0]    codeIn,
  // internal data operand read
  output logic                               dataRd,
  output logic      [itc_pkg::BYTE_W-1:0]    dataAddr,
  input  wire logic [itc_pkg::BYTE_W-1:0]    dataIn,
  // register port
  input  wire logic [itc_pkg::BYTE_W-1:0]    regAddr,
  input  wire logic [itc_pkg::BYTE_W-1:0]    regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [itc_pkg::BYTE_W-1:0]    regRdata,
  // status
  output logic                               carryFlag,
  output logic                               signedWrapFlag,
  output logic                               auxCarryFlag,
  output logic                               onesOddFlag,
  output logic      [itc_pkg::PH_W-1:0]      machinePhase,
  output logic                               instrDone
);

  generate
    if (ADDR_W != PC_W) begin : g_bad_addr
      $error("itc_core: ADDR_W must equal the 16-bit program counter width");
    end
  endgenerate

  // ---- decode helpers
  // below nibble 4 these rows hold jumps and rotates, not arithmetic
  function automatic logic isArith(input logic [7:0] op);
    isArith = ((op[7:4] == HN_ADD) || (op[7:4] == HN_ADD_WITH_CARRY) || (op[7:4] == HN_SUBTRACT_WITH_BORROW)) &&
              (op[3:0] >= LN_IMM);
  endfunction

  function automatic logic isCjne(input logic [7:0] op);
    isCjne = (op[7:4] == HN_COMPARE_JUMP_UNEQUAL) && (op[3:0] >= LN_IMM);
  endfunction

  function automatic logic isBitOp(input logic [7:0] op);
    isBitOp = (op == OP_ANLC) || (op == OP_ANLCN) || (op == OP_ORLC) ||
              (op == OP_ORLCN) || (op == OP_MOVC);
  endfunction

  function automatic logic isJump(input logic [7:0] op);
    isJump = (op[4:0] == ABS_JUMP_PAT) || (op == OP_LJMP) || (op == OP_LCALL) ||
             (op == OP_SJMP) || isCjne(op);
  endfunction

  function automatic logic [1:0] opBytes(input logic [7:0] op);
    if (op[4:0] == ABS_JUMP_PAT || op == OP_SJMP || isBitOp(op)) begin
      opBytes = LEN_TWO;
    end else if (op == OP_LJMP || op == OP_LCALL || isCjne(op)) begin
      opBytes = LEN_THREE;
    end else if (isArith(op) && (op[3:0] == LN_IMM || op[3:0] == LN_DIR)) begin
      opBytes = LEN_TWO;
    end else begin
      opBytes = LEN_ONE;
    end
  endfunction

  // index of the last machine cycle: byte count minus one, plus one for jumps
  function automatic logic [1:0] lastCycOf(input logic [7:0] op);
    lastCycOf = opBytes(op) - CYC_STEP + {1'b0, isJump(op)};
  endfunction

  function automatic logic usesInd(input logic [7:0] op);
    usesInd = (isArith(op) || isCjne(op)) && (op[3:0] == LN_IND0 || op[3:0] == LN_IND1);
  endfunction

  function automatic logic needsData(input logic [7:0] op);
    needsData = isBitOp(op) || usesInd(op) ||
                ((isArith(op) || isCjne(op)) && op[3:0] == LN_DIR);
  endfunction

  // ---- state
  logic [PH_W-1:0]   phase_ff, nxt_phase;
  logic [1:0]        cyc_ff, nxt_cyc;
  logic [7:0]        op_ff, nxt_op;
  logic [7:0]        b1_ff, nxt_b1;
  logic [7:0]        b2_ff, nxt_b2;
  logic [PC_W-1:0]   pc_ff, nxt_pc;
  logic [7:0]        acc_ff, nxt_acc;
  logic [7:0]        secAcc_ff, nxt_secAcc;
  logic [7:0]        bank_ff [8];
  logic [7:0]        nxt_bank [8];
  logic              cy_ff, nxt_cy;
  logic              ov_ff, nxt_ov;
  logic              ac_ff, nxt_ac;
  logic              odd_ff, nxt_odd;
  logic              fetchReq_ff, nxt_fetchReq;
  logic [PC_W-1:0]   fetchAddr_ff, nxt_fetchAddr;
  logic              dataRd_ff, nxt_dataRd;
  logic [7:0]        dataAddr_ff, nxt_dataAddr;
  logic [7:0]        rdata_ff, nxt_rdata;
  logic              done_ff, nxt_done;

  // ---- alu
  itc_alu_op_t aluOp;
  logic [7:0]  aluB, aluRes, aluHi;
  logic        aluCin, aluCy, aluOv, aluAc;
  logic [7:0]  operand;
  logic [7:0]  cmpLhs, cmpRhs;
  logic [8:0]  daTmp;
  logic        bitVal;
  logic [7:0]  bitByte;

  itc_alu #(.WIDTH(BYTE_W)) u_alu (
    .op       (aluOp),
    .opA      (acc_ff),
    .opB      (aluB),
    .carryIn  (aluCin),
    .result   (aluRes),
    .resultHi (aluHi),
    .carryOut (aluCy),
    .wrapOut  (aluOv),
    .auxOut   (aluAc)
  );

  // direct addresses of the accumulator, second accumulator and status word are served locally
  always_comb begin
    case (dataAddr_ff)
      OFS_ACC:        operand = acc_ff;
      OFS_SECOND_ACC: operand = secAcc_ff;
      OFS_STATUS:     operand = {cy_ff, ac_ff, 3'h0, ov_ff, 1'b0, odd_ff};
      default:        operand = dataIn;
    endcase
  end

  // operand routing for the alu and compare
  always_comb begin
    aluOp  = ALU_ADD;
    aluCin = 1'b0;
    aluB   = bank_ff[op_ff[2:0]];
    cmpLhs = acc_ff;
    cmpRhs = b1_ff;
    bitVal = operand[b1_ff[2:0]];
    if (op_ff[3:0] == LN_IMM) begin
      aluB = b1_ff;
    end else if (op_ff[3:0] == LN_DIR || usesInd(op_ff)) begin
      aluB = operand;
    end
    case (op_ff[7:4])
      HN_ADD_WITH_CARRY: aluCin = cy_ff;
      HN_SUBTRACT_WITH_BORROW: begin
        aluOp  = ALU_SUB;
        aluCin = cy_ff;
      end
      default: aluCin = 1'b0;
    endcase
    if (op_ff == OP_MUL) begin
      aluOp = ALU_MUL;
      aluB  = secAcc_ff;
    end else if (op_ff == OP_DIV) begin
      aluOp = ALU_DIV;
      aluB  = secAcc_ff;
    end
    if (op_ff[3:0] == LN_DIR) begin
      cmpRhs = operand;
    end else if (usesInd(op_ff)) begin
      cmpLhs = operand;
    end else if (op_ff[3]) begin
      cmpLhs = bank_ff[op_ff[2:0]];
    end
  end

  // ---- sequencing, execution and register port
  always_comb begin
    nxt_phase     = phase_ff + PH_STEP;
    nxt_cyc       = cyc_ff;
    nxt_op        = op_ff;
    nxt_b1        = b1_ff;
    nxt_b2        = b2_ff;
    nxt_pc        = pc_ff;
    nxt_acc       = acc_ff;
    nxt_secAcc    = secAcc_ff;
    nxt_bank      = bank_ff;
    nxt_cy        = cy_ff;
    nxt_ov        = ov_ff;
    nxt_ac        = ac_ff;
    nxt_done      = 1'b0;
    nxt_rdata     = RST_BYTE;
    daTmp         = '0;
    bitByte       = '0;

    // software writes first; execution below overrides in the same cycle
    if (regWr) begin
      if (regAddr <= OFS_BANK_TOP) begin
        nxt_bank[regAddr[2:0]] = regWdata;
      end
      case (regAddr)
        OFS_ACC:        nxt_acc = regWdata;
        OFS_SECOND_ACC: nxt_secAcc = regWdata;
        OFS_STATUS: begin
          nxt_cy = regWdata[SB_CY];
          nxt_ac = regWdata[SB_AC];
          nxt_ov = regWdata[SB_OV];
        end
        default: nxt_acc = nxt_acc;
      endcase
    end
    if (regRd) begin
      if (regAddr <= OFS_BANK_TOP) begin
        nxt_rdata = bank_ff[regAddr[2:0]];
      end
      case (regAddr)
        OFS_ACC:        nxt_rdata = acc_ff;
        OFS_SECOND_ACC: nxt_rdata = secAcc_ff;
        OFS_STATUS:     nxt_rdata = {cy_ff, ac_ff, 3'h0, ov_ff, 1'b0, odd_ff};
        default:        nxt_rdata = nxt_rdata;
      endcase
    end

    // one code byte captured per machine cycle, only while bytes remain
    if (phase_ff == PH_CAPTURE && fetchReq_ff == 1'b0 &&
        (cyc_ff == CYC_FIRST || cyc_ff < opBytes(op_ff))) begin
      case (cyc_ff)
        CYC_FIRST:  nxt_op = codeIn;
        CYC_SECOND: nxt_b1 = codeIn;
        default:    nxt_b2 = codeIn;
      endcase
      nxt_pc = pc_ff + 16'h0001;
    end

    if (phase_ff == PH_EXEC) begin
      if (cyc_ff == lastCycOf(op_ff)) begin
        nxt_cyc  = CYC_FIRST;
        nxt_done = 1'b1;
        if (isArith(op_ff)) begin
          nxt_acc = aluRes;
          nxt_cy  = aluCy;
          nxt_ov  = aluOv;
          nxt_ac  = aluAc;
        end else if (isCjne(op_ff)) begin
          nxt_cy = cmpLhs < cmpRhs;
          if (cmpLhs != cmpRhs) begin
            nxt_pc = pc_ff + {{8{b2_ff[7]}}, b2_ff};
          end
        end else if (isBitOp(op_ff)) begin
          case (op_ff)
            OP_ANLC:  nxt_cy = cy_ff & bitVal;
            OP_ANLCN: nxt_cy = cy_ff & ~bitVal;
            OP_ORLC:  nxt_cy = cy_ff | bitVal;
            OP_ORLCN: nxt_cy = cy_ff | ~bitVal;
            default:  nxt_cy = bitVal;
          endcase
        end else if (op_ff[4:0] == ABS_JUMP_PAT) begin
          nxt_pc = {pc_ff[15:11], op_ff[7:5], b1_ff};
        end else begin
          case (op_ff)
            OP_MUL, OP_DIV: begin
              nxt_acc    = aluRes;
              nxt_secAcc = aluHi;
              nxt_cy     = 1'b0;
              nxt_ov     = aluOv;
            end
            OP_DA: begin
              daTmp = {1'b0, acc_ff};
              if (acc_ff[3:0] > BCD_LIMIT || ac_ff) begin
                daTmp = daTmp + {1'b0, BCD_FIX_LO};
              end
              if (daTmp[7:4] > BCD_LIMIT || daTmp[8] || cy_ff) begin
                daTmp = daTmp + {1'b0, BCD_FIX_HI};
              end
              nxt_acc = daTmp[7:0];
              nxt_cy  = cy_ff | daTmp[8];
            end
            OP_RRC: begin
              nxt_acc = {cy_ff, acc_ff[7:1]};
              nxt_cy  = acc_ff[0];
            end
            OP_RLC: begin
              nxt_acc = {acc_ff[6:0], cy_ff};
              nxt_cy  = acc_ff[7];
            end
            OP_CLRC:  nxt_cy = 1'b0;
            OP_SETBC: nxt_cy = 1'b1;
            OP_CPLC:  nxt_cy = ~cy_ff;
            OP_LJMP, OP_LCALL: nxt_pc = {b1_ff, b2_ff};
            OP_SJMP:  nxt_pc = pc_ff + {{8{b1_ff[7]}}, b1_ff};
            default:  nxt_pc = nxt_pc; // OP_NOP and unlisted opcodes
          endcase
        end
      end else begin
        nxt_cyc = cyc_ff + CYC_STEP;
      end
    end

    // fetch strobe for the coming machine cycle
    nxt_fetchReq  = (nxt_phase == PH_FETCH) &&
                    (nxt_cyc == CYC_FIRST || nxt_cyc < opBytes(nxt_op));
    nxt_fetchAddr = nxt_pc;
    bitByte       = nxt_b1[7] ? {nxt_b1[7:3], 3'h0} : BIT_BYTE_BASE + {4'h0, nxt_b1[6:3]};
    nxt_dataAddr  = usesInd(nxt_op) ? nxt_bank[{2'h0, nxt_op[0]}] :
                    (isBitOp(nxt_op) ? bitByte : nxt_b1);
    nxt_dataRd    = (phase_ff == PH_CAPTURE) && (cyc_ff == lastCycOf(nxt_op)) &&
                    needsData(nxt_op);
    nxt_odd       = ^nxt_acc;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      phase_ff     <= PH_EXEC;
      cyc_ff       <= CYC_FIRST;
      op_ff        <= OP_NOP;
      b1_ff        <= RST_BYTE;
      b2_ff        <= RST_BYTE;
      pc_ff        <= RST_PC;
      acc_ff       <= RST_BYTE;
      secAcc_ff    <= RST_BYTE;
      bank_ff      <= '{default: RST_BYTE};
      cy_ff        <= 1'b0;
      ov_ff        <= 1'b0;
      ac_ff        <= 1'b0;
      odd_ff       <= 1'b0;
      fetchReq_ff  <= 1'b0;
      fetchAddr_ff <= RST_PC;
      dataRd_ff    <= 1'b0;
      dataAddr_ff  <= RST_BYTE;
      rdata_ff     <= RST_BYTE;
      done_ff      <= 1'b0;
    end else begin
      phase_ff     <= nxt_phase;
      cyc_ff       <= nxt_cyc;
      op_ff        <= nxt_op;
      b1_ff        <= nxt_b1;
      b2_ff        <= nxt_b2;
      pc_ff        <= nxt_pc;
      acc_ff       <= nxt_acc;
      secAcc_ff    <= nxt_secAcc;
      bank_ff      <= nxt_bank;
      cy_ff        <= nxt_cy;
      ov_ff        <= nxt_ov;
      ac_ff        <= nxt_ac;
      odd_ff       <= nxt_odd;
      fetchReq_ff  <= nxt_fetchReq;
      fetchAddr_ff <= nxt_fetchAddr;
      dataRd_ff    <= nxt_dataRd;
      dataAddr_ff  <= nxt_dataAddr;
      rdata_ff     <= nxt_rdata;
      done_ff      <= nxt_done;
    end
  end

  assign fetchReq       = fetchReq_ff;
  assign fetchAddr      = fetchAddr_ff;
  assign dataRd         = dataRd_ff;
  assign dataAddr       = dataAddr_ff;
  assign regRdata       = rdata_ff;
  assign carryFlag      = cy_ff;
  assign signedWrapFlag = ov_ff;
  assign auxCarryFlag   = ac_ff;
  assign onesOddFlag    = odd_ff;
  assign machinePhase   = phase_ff;
  assign instrDone      = done_ff;

endmodule

/* File: hdl/itc_pkg.sv */
// constants and types shared by the instruction timing and flag core
package itc_pkg;

  // machine cycle framing
  localparam int         CLKS_PER_MC = 4;
  localparam int         BYTE_W      = 8;
  localparam int         PC_W        = 16;
  localparam int         PH_W        = $clog2(CLKS_PER_MC);
  localparam logic [1:0] PH_FETCH    = 2'h0;
  localparam logic [1:0] PH_CAPTURE  = 2'h2;
  localparam logic [1:0] PH_EXEC     = 2'h3;
  localparam logic [1:0] PH_STEP     = 2'h1;

  // instruction length and cycle counts
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_FIRST = 2'h0;
  localparam logic [1:0] CYC_SECOND = 2'h1;
  localparam logic [1:0] CYC_STEP  = 2'h1;

  // register port map
  localparam logic [7:0] OFS_BANK_TOP   = 8'h07;
  localparam logic [7:0] OFS_STATUS     = 8'hd0;
  localparam logic [7:0] OFS_ACC        = 8'he0;
  localparam logic [7:0] OFS_SECOND_ACC = 8'hf0;

  // status word bit positions
  localparam int SB_CY = 7;
  localparam int SB_AC = 6;
  localparam int SB_OV = 2;
  localparam int SB_P  = 0;

  // reset values
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC   = 16'h0000;

  // single opcodes
  localparam logic [7:0] OP_NOP   = 8'h00;
  localparam logic [7:0] OP_LJMP  = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_RRC   = 8'h13;
  localparam logic [7:0] OP_RLC   = 8'h33;
  localparam logic [7:0] OP_ORLC  = 8'h72;
  localparam logic [7:0] OP_SJMP  = 8'h80;
  localparam logic [7:0] OP_ANLC  = 8'h82;
  localparam logic [7:0] OP_DIV   = 8'h84;
  localparam logic [7:0] OP_ORLCN = 8'ha0;
  localparam logic [7:0] OP_MOVC  = 8'ha2;
  localparam logic [7:0] OP_MUL   = 8'ha4;
  localparam logic [7:0] OP_ANLCN = 8'hb0;
  localparam logic [7:0] OP_CPLC  = 8'hb3;
  localparam logic [7:0] OP_CLRC  = 8'hc3;
  localparam logic [7:0] OP_SETBC = 8'hd3;
  localparam logic [7:0] OP_DA    = 8'hd4;

  // opcode families by nibble
  localparam logic [3:0] HN_ADD  = 4'h2;
  localparam logic [3:0] HN_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] HN_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] HN_COMPARE_JUMP_UNEQUAL = 4'hb;
  localparam logic [3:0] LN_IMM  = 4'h4;
  localparam logic [3:0] LN_DIR  = 4'h5;
  localparam logic [3:0] LN_IND0 = 4'h6;
  localparam logic [3:0] LN_IND1 = 4'h7;
  localparam logic [4:0] ABS_JUMP_PAT = 5'h01;

  // bit addressing and decimal adjust
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [3:0] BCD_LIMIT     = 4'h9;
  localparam logic [7:0] BCD_FIX_LO    = 8'h06;
  localparam logic [7:0] BCD_FIX_HI    = 8'h60;

  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_MUL, ALU_DIV} itc_alu_op_t;

endpackage

/* File: tb/itc_code_mem.sv */
// program memory and internal data model facing the core
`timescale 1ns/10ps
module itc_code_mem (
  // clock
  input wire logic        clk_sys,
  // code fetch
  input wire logic        fetchReq,
  input wire logic [15:0] fetchAddr,
  output logic      [7:0] codeIn,
  // data read
  input wire logic        dataRd,
  input wire logic  [7:0] dataAddr,
  output logic      [7:0] dataIn
);
  logic [7:0] code [0:255];
  logic [7:0] dmem [0:255];
  logic [1:0] hold = 2'h0;
  logic [7:0] noise = 8'ha5;
  initial codeIn = 8'h5a;
  // byte stands until sampled two clocks on, then scrambles so stale data never passes
  always @(posedge clk_sys) begin
    noise <= ~noise;
    if (fetchReq) begin
      codeIn <= code[fetchAddr[7:0]];
      hold <= 2'h2;
    end else begin
      if (hold != 2'h2) codeIn <= ~codeIn;
      if (hold != 2'h0) hold <= hold - 2'h1;
    end
  end
  assign dataIn = dataRd ? dmem[dataAddr] : noise;
endmodule

/* File: tb/itc_core_sva.sv */
// assertion checker on the core's ports
`timescale 1ns/10ps
module itc_core_sva
  import itc_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // fetch and data
  input wire logic       fetchReq,
  input wire logic       dataRd,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // status
  input wire logic       carryFlag,
  input wire logic       onesOddFlag,
  input wire logic [1:0] machinePhase,
  input wire logic       instrDone
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_PHASE_STEP: assert property (
    $past(resetn) |-> machinePhase - $past(machinePhase) == 2'h1)
    else $error("phase did not step by one");
  AST_FETCH_PHASE: assert property (
    fetchReq |-> machinePhase == PH_FETCH) else $error("fetch outside phase 0");
  AST_FETCH_GAP: assert property (
    fetchReq |=> !fetchReq [*3]) else $error("two fetches in one cycle");
  AST_DONE_FETCH: assert property (
    instrDone |-> machinePhase == PH_FETCH && fetchReq) else $error("done without fetch");
  AST_DATA_LAST: assert property (
    dataRd |-> machinePhase == PH_EXEC ##1 instrDone) else $error("data read misplaced");
  AST_ODD_TRACK: assert property (
    regRd && regAddr == OFS_ACC && machinePhase != PH_EXEC |=> onesOddFlag == ^regRdata)
    else $error("odd-ones flag off accumulator");
  AST_SECOND_ACC: assert property (
    regWr && regAddr == OFS_SECOND_ACC && machinePhase != PH_EXEC
    ##1 regRd && regAddr == OFS_SECOND_ACC && machinePhase != PH_EXEC
    |=> regRdata == $past(regWdata, 2)) else $error("second accumulator lost write");
  AST_FLAG_HOLD: assert property (
    machinePhase != PH_EXEC && !(regWr && regAddr == OFS_STATUS) |=> $stable(carryFlag))
    else $error("carry moved outside result edge");
endmodule

bind itc_core itc_core_sva u_sva (
  .clk_sys(clk_sys), .resetn(resetn), .fetchReq(fetchReq), .dataRd(dataRd),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .carryFlag(carryFlag), .onesOddFlag(onesOddFlag),
  .machinePhase(machinePhase), .instrDone(instrDone)
);

/* File: tb/itc_core_tb_top.sv */
// random instruction stream checked against a timing and flag model
`timescale 1ns/10ps
module itc_core_tb_top;
  import itc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic [7:0]  regRdata, codeIn, dataAddr, dataIn, op, d, b1, b2, v;
  logic [15:0] fetchAddr;
  logic        fetchReq, dataRd, carryFlag, signedWrapFlag, auxCarryFlag;
  logic        onesOddFlag, instrDone;
  logic [1:0]  machinePhase;
  logic [31:0] seed = 32'h1197;
  logic [7:0]  opTab [19] = '{8'h00, 8'h24, 8'h25, 8'h28, 8'h34, 8'h94, 8'hc3, 8'hd3,
    8'hb3, 8'ha4, 8'h84, 8'h13, 8'h33, 8'hd4, 8'h02, 8'h01, 8'h80, 8'hb4, 8'h2f};
  int          acc, bReg, cy, ac, ov, c6, r, pc, nb, nc, w;
  int          clkCnt, lastDone, fetchCnt, errorCnt, samplesChecked;
  int          rb [8];
  int          expCyc[$], expByt[$], expAcc[$], seenIv[$], seenFt[$];
  logic [3:0]  expFl[$], seenFl[$];

  always #20 clk_sys = ~clk_sys;

  itc_core dut (.clk_sys(clk_sys), .resetn(resetn), .fetchReq(fetchReq),
    .fetchAddr(fetchAddr), .codeIn(codeIn), .dataRd(dataRd), .dataAddr(dataAddr),
    .dataIn(dataIn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .carryFlag(carryFlag),
    .signedWrapFlag(signedWrapFlag), .auxCarryFlag(auxCarryFlag),
    .onesOddFlag(onesOddFlag), .machinePhase(machinePhase), .instrDone(instrDone));
  itc_code_mem pm (.clk_sys(clk_sys), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .codeIn(codeIn), .dataRd(dataRd), .dataAddr(dataAddr), .dataIn(dataIn));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] x);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= x;
    @(posedge clk_sys);
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] x);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    x = regRdata;
  endtask

  // borrow reads as carry for subtraction, as in the classic core
  task automatic arith(input int x, input int cin, input int sub);
    if (sub) begin
      r = acc - x - cin;
      cy = acc < x + cin;
      ac = (acc & 15) < (x & 15) + cin;
      c6 = (acc & 127) < (x & 127) + cin;
    end else begin
      r = acc + x + cin;
      cy = r > 255;
      ac = (acc & 15) + (x & 15) + cin > 15;
      c6 = (acc & 127) + (x & 127) + cin > 127;
    end
    ov = c6 ^ cy;
    acc = r & 255;
  endtask

  always @(negedge clk_sys) begin
    clkCnt++;
    if (instrDone === 1'b1) begin
      // the reset slot ends with a done that no fetch precedes
      if (lastDone > 0) begin
        seenIv.push_back(clkCnt - lastDone);
        seenFt.push_back(fetchCnt);
        seenFl.push_back({carryFlag, signedWrapFlag, auxCarryFlag, onesOddFlag});
      end
      lastDone = clkCnt;
      fetchCnt = 0;
    end
    if (fetchReq === 1'b1) fetchCnt++;
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      pm.code[i] = 8'h00;
      pm.dmem[i] = rnd() & 255;
    end
    for (int i = 0; i < 8; i++) rb[i] = rnd() & 255;
    bReg = rnd() & 255;
    v = bReg[7:0];
    // leading no-ops give the register preload time before real work starts
    for (int i = 0; i < 60; i++) begin
      op = (i < 6) ? 8'h00 : opTab[rnd() % 19];
      d = rnd() & 255;
      b1 = d;
      b2 = 8'h00;
      nb = 1;
      nc = 1;
      if (op == 8'h28) op = op | (d & 8'h07);
      case (op)
        8'h24, 8'h34, 8'h94: begin
          nb = 2;
          arith(d, (op == 8'h24) ? 0 : cy, op == 8'h94);
        end
        8'h25: begin
          nb = 2;
          b1 = 8'h40 | (d & 8'h3f);
          arith(pm.dmem[b1], 0, 0);
        end
        8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f: arith(rb[op & 7], 0, 0);
        8'hc3: cy = 0;
        8'hd3: cy = 1;
        8'hb3: cy = !cy;
        8'ha4: begin
          r = acc * bReg;
          acc = r & 255;
          bReg = r >> 8;
          cy = 0;
          ov = r > 255;
        end
        8'h84: begin
          cy = 0;
          ov = bReg == 0;
          if (bReg != 0) begin
            r = acc / bReg;
            bReg = acc % bReg;
            acc = r;
          end
        end
        8'h13: begin
          r = acc & 1;
          acc = (acc >> 1) | (cy << 7);
          cy = r;
        end
        8'h33: begin
          r = acc >> 7;
          acc = ((acc << 1) & 255) | cy;
          cy = r;
        end
        8'hd4: begin
          if ((acc & 15) > 9 || ac) acc = acc + 6;
          if (acc > 255) cy = 1;
          acc = acc & 255;
          if ((acc >> 4) > 9 || cy) acc = acc + 96;
          if (acc > 255) cy = 1;
          acc = acc & 255;
        end
        8'h02: begin
          nb = 3;
          nc = 4;
          b1 = 8'h00;
          b2 = pc + 3;
        end
        8'h01, 8'h80: begin
          nb = 2;
          nc = 3;
          b1 = (op == 8'h01) ? pc + 2 : 8'h00;
        end
        8'hb4: begin
          nb = 3;
          nc = 4;
          cy = acc < d;
        end
        default: ;
      endcase
      if (nc == 1) nc = nb;
      pm.code[pc] = op;
      if (nb > 1) pm.code[pc + 1] = b1;
      if (nb > 2) pm.code[pc + 2] = b2;
      pc += nb;
      expCyc.push_back(nc);
      expByt.push_back(nb);
      expAcc.push_back(acc);
      expFl.push_back({cy[0], ov[0], ac[0], ^acc[7:0]});
    end
    repeat (8) @(posedge clk_sys);
    chk("fetch in reset", {7'h00, fetchReq}, 8'h00);
    resetn <= 1'b1;
    regWrite(8'h00, rb[0][7:0]);
    regWrite(OFS_SECOND_ACC, v);
    regWr <= 1'b0;
    regRead(OFS_SECOND_ACC, b1);
    chk("second acc", b1, v);
    @(posedge clk_sys);
    for (int i = 1; i < 8; i++) regWrite(i[7:0], rb[i][7:0]);
    regWr <= 1'b0;
    regRead(OFS_STATUS, b1);
    chk("status after reset", b1, 8'h00);
    @(posedge clk_sys);
    regRead(8'h90, b1);
    chk("unmapped read", b1, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 60; k++) begin
      w = 0;
      do begin
        @(posedge clk_sys);
        w++;
      end while (seenIv.size() <= k && w < 400);
      if (seenIv.size() <= k) begin
        errorCnt++;
        printVerdict();
      end
      chk("fetches", 8'(seenFt[k]), 8'(expByt[k]));
      if (k > 0) chk("clocks", 8'(seenIv[k]), 8'(4 * expCyc[k]));
      chk("flags", {4'h0, seenFl[k]}, {4'h0, expFl[k]});
      if (k >= 6) begin
        regRead(OFS_ACC, b1);
        chk("accumulator", b1, 8'(expAcc[k]));
      end
    end
    $display("test program done");
    printVerdict();
  end
endmodule
